//--- rtl/doze_timer.sv
// doze duty cycle and listen frequency selection
`timescale 1ns/1ns
module doze_timer
	import wake_seq_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst_b,
	input  wire logic       dozing,
	input  wire logic       use_ctrl,
	input  wire logic [7:0] low_freq,
	input  wire logic [7:0] freq_step,
	input  wire logic [3:0] freq_count,
	output logic            rx_awake,
	output logic      [7:0] listen_freq
);
	typedef struct packed {
		logic [CNT_W-1:0] cyc;
		logic [CNT_W-1:0] dwell;
		logic [3:0]       idx;
		logic             awake;
		logic [7:0]       freq;
	} dz_t;
	dz_t st, next_st;

	always_comb begin
		next_st = st;
		if (!dozing) begin
			next_st = '0;
			next_st.freq = low_freq;
		end else begin
			// 150 ms frame, receiver powered only in its first 8 ms
			if (st.cyc >= CNT_W'(DOZE_CYCLE_CYC - 1))
				next_st.cyc = '0;
			else
				next_st.cyc = st.cyc + 1'b1;
			next_st.awake = (next_st.cyc < CNT_W'(DOZE_ACTIVE_CYC));
			if (use_ctrl) begin
				next_st.idx = '0;
				next_st.freq = low_freq;
			end else if (st.dwell >= CNT_W'(DOZE_DWELL_CYC - 1)) begin
				next_st.dwell = '0;
				if (st.idx + 1'b1 >= freq_count)
					next_st.idx = '0;
				else
					next_st.idx = st.idx + 1'b1;
				next_st.freq = 8'(low_freq + next_st.idx * freq_step);
			end else begin
				next_st.dwell = st.dwell + 1'b1;
			end
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b)
			st <= '0;
		else
			st <= next_st;
	end

	assign rx_awake = st.awake;
	assign listen_freq = st.freq;
endmodule

//--- rtl/radio_wakeup_sequencer.sv
// relayed wake command sequencer, repeater and doze control
// Function
// - broadcast wake: receivers send no acknowledge
// - broadcast: success after accepted, after retransmissions
// - command: at, letters, repeater, destination, CR LF
// - destination is station address; 255 broadcasts
// - accepted response, then requests to repeater
// - repeat request every 200 ms, retry count
// - repeater drops mismatched address when checking
// - repeater sends wake requests for 160 ms
// - repeater ignores acks, sends none back
// - relayed wake: failure after accepted unless broadcast
// - doze config bit 6 selects control frequency
// - dozing with control frequency listens there only
// - control frequency is lowest, excluded from data; code excludes it only while doze config bit 7 is also set
// - default group: 0 control, 8 and 16 data
// - single frequency: control selection has no effect
// - control frequency: 2 sends, 320 ms, stop; code spaces the 2 sends 200 ms apart, 400 ms to the final response
// - no control: 4 per frequency, group times two
// - retry count ignored in multi-frequency group
// - doze config bit 7 enables doze behaviour
// - doze: 150 ms cycle, 8 ms active
// - doze scans group 150 ms each, else lowest
`timescale 1ns/1ns
module radio_wakeup_sequencer
	import wake_seq_pkg::*;
(
	input  wire logic       ref_clk,
	input  wire logic       rst_b,
	// host serial side, one byte per valid cycle
	input  wire logic       host_valid,
	input  wire logic [7:0] host_byte,
	output logic            resp_valid,
	output resp_t           resp_code,
	// settings
	input  wire logic [7:0] station_address_setting,
	input  wire logic [7:0] channel_group_setting,
	input  wire logic [7:0] retry_count_setting,
	input  wire logic [7:0] relay_address_check_setting,
	input  wire logic [7:0] doze_config_setting,
	input  wire logic       single_freq_mode,
	input  wire logic [3:0] group_freq_count,
	input  wire logic [7:0] group_low_freq,
	input  wire logic [7:0] group_freq_step,
	input  wire logic       dozing,
	// radio side
	input  wire logic       rx_req_valid,
	input  wire logic [7:0] rx_req_repeater,
	input  wire logic [7:0] rx_req_dest,
	input  wire logic       rx_ack_valid,
	output logic            tx_req_valid,
	output logic      [7:0] tx_req_repeater,
	output logic      [7:0] tx_req_dest,
	output logic            tx_wake_valid,
	output logic      [7:0] tx_wake_dest,
	output logic      [7:0] tx_freq,
	output logic            tx_ack_valid,
	output logic            ctrl_freq_active,
	output logic      [7:0] data_low_freq,
	output logic            rx_awake,
	output logic      [7:0] listen_freq
);
	typedef struct packed {
		parse_t           pst;
		logic [7:0]       rpt_acc;
		logic [7:0]       dst_acc;
		seq_t             seq;
		logic [7:0]       rpt;
		logic [7:0]       dst;
		logic [7:0]       sends_left;
		logic [CNT_W-1:0] timer;
		logic [CNT_W-1:0] relay_timer;
		logic [7:0]       relay_dst;
		logic             resp_v;
		resp_t            resp;
		logic             req_v;
	} st_t;
	st_t st, next_st;

	// decimal digit test, used for both address fields
	function automatic logic is_digit(input logic [7:0] b);
		return (b >= 8'h30) && (b <= 8'h39);
	endfunction

	function automatic logic [7:0] acc_digit(input logic [7:0] acc,
		input logic [7:0] b);
		return 8'(acc * 8'hA + (b - 8'h30));
	endfunction

	logic doze_en;
	logic use_ctrl;
	logic addr_ok;
	assign doze_en = doze_config_setting[DOZE_EN_BIT];
	// ignored when only one frequency exists
	assign use_ctrl = doze_config_setting[CTRL_FREQ_BIT]
		&& !single_freq_mode;
	assign addr_ok = !relay_address_check_setting[ADDR_CHK_BIT]
		|| (rx_req_repeater == station_address_setting);

	always_comb begin
		next_st = st;
		next_st.resp_v = 1'b0;
		next_st.req_v = 1'b0;
		// command parser: ignores bytes while a sequence runs
		if (host_valid && st.seq == S_IDLE) begin
			case (st.pst)
			P_AT: if (host_byte == ASCII_AT) next_st.pst = P_C1;
			P_C1: next_st.pst = (host_byte == ASCII_R) ? P_C2 : P_AT;
			P_C2: next_st.pst = (host_byte == ASCII_L) ? P_C3 : P_AT;
			P_C3: begin
				next_st.rpt_acc = '0;
				next_st.pst = (host_byte == ASCII_R) ? P_RPT : P_AT;
			end
			P_RPT: begin
				if (is_digit(host_byte)) begin
					next_st.rpt_acc = acc_digit(st.rpt_acc, host_byte);
				end else begin
					next_st.dst_acc = '0;
					next_st.pst = P_DST;
				end
			end
			P_DST: begin
				if (is_digit(host_byte))
					next_st.dst_acc = acc_digit(st.dst_acc, host_byte);
				else if (host_byte == ASCII_CR)
					next_st.pst = P_LF;
				else if (host_byte != 8'h20)
					next_st.pst = P_AT;
			end
			P_LF: begin
				next_st.pst = P_AT;
				if (host_byte == ASCII_LF) begin
					next_st.rpt = st.rpt_acc;
					next_st.dst = st.dst_acc;
					next_st.seq = S_ACCEPT;
				end
			end
			default: next_st.pst = P_AT;
			endcase
		end
		case (st.seq)
		S_IDLE: ;
		S_ACCEPT: begin
			next_st.resp_v = 1'b1;
			next_st.resp = RESP_ACCEPTED;
			next_st.timer = '0;
			// group mode fixes the count, else the retry setting
			if (single_freq_mode)
				next_st.sends_left = retry_count_setting;
			else if (use_ctrl)
				next_st.sends_left = 8'(CTRL_REPEATS);
			else
				next_st.sends_left = 8'(SCAN_REPEATS
					* group_freq_count * 2);
			next_st.seq = S_SEND;
		end
		S_SEND: begin
			next_st.req_v = 1'b1;
			next_st.timer = '0;
			next_st.seq = S_WAIT;
		end
		S_WAIT: begin
			next_st.timer = st.timer + 1'b1;
			// the send cycle itself closes the period, so wait one less
			if (st.timer >= CNT_W'(REQ_PERIOD_CYC - 2)) begin
				if (st.sends_left <= 8'h1) begin
					next_st.sends_left = '0;
					next_st.seq = S_FINAL;
				end else begin
					next_st.sends_left = st.sends_left - 1'b1;
					next_st.seq = S_SEND;
				end
			end
		end
		S_FINAL: begin
			next_st.resp_v = 1'b1;
			// no ack path through a repeater, so unicast fails
			next_st.resp = (st.dst == BCAST_ADDR) ? RESP_SUCCESS
				: RESP_FAILURE;
			next_st.seq = S_IDLE;
		end
		default: next_st.seq = S_IDLE;
		endcase
		// repeater role
		if (st.relay_timer != '0)
			next_st.relay_timer = st.relay_timer - 1'b1;
		if (rx_req_valid && addr_ok) begin
			next_st.relay_timer = CNT_W'(RELAY_BURST_CYC);
			next_st.relay_dst = rx_req_dest;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign resp_valid = st.resp_v;
	assign resp_code = st.resp;
	assign tx_req_valid = st.req_v;
	assign tx_req_repeater = st.rpt;
	assign tx_req_dest = st.dst;
	assign tx_wake_valid = (st.relay_timer != '0);
	assign tx_wake_dest = st.relay_dst;
	// acks seen on rx_ack_valid never forwarded by the repeater
	assign tx_ack_valid = 1'b0;
	assign ctrl_freq_active = use_ctrl && doze_en;
	assign tx_freq = use_ctrl ? group_low_freq : listen_freq;
	// lowest frequency reserved for waking when control and doze are both on
	assign data_low_freq = ctrl_freq_active
		? 8'(group_low_freq + group_freq_step) : group_low_freq;

	doze_timer u_doze (
		.ref_clk    (ref_clk),
		.rst_b      (rst_b),
		.dozing     (dozing && doze_en),
		.use_ctrl   (use_ctrl),
		.low_freq   (group_low_freq),
		.freq_step  (group_freq_step),
		.freq_count (group_freq_count),
		.rx_awake   (rx_awake),
		.listen_freq(listen_freq)
	);
endmodule

//--- rtl/wake_seq_pkg.sv
// constants and types shared by the wake sequencer
package wake_seq_pkg;
	localparam int CLK_HZ = 100_000_000;
	localparam int TIME_UNIT_HZ = 1000;
	localparam int REQ_PERIOD_MS = 200;
	localparam int RELAY_BURST_MS = 160;
	localparam int CTRL_PKT_MS = 160;
	localparam int DOZE_CYCLE_MS = 150;
	localparam int DOZE_ACTIVE_MS = 8;
	localparam int DOZE_DWELL_MS = 150;
	localparam int CYC_PER_MS = CLK_HZ / TIME_UNIT_HZ;
	localparam int REQ_PERIOD_CYC = REQ_PERIOD_MS * CYC_PER_MS;
	localparam int RELAY_BURST_CYC = RELAY_BURST_MS * CYC_PER_MS;
	localparam int CTRL_PKT_CYC = CTRL_PKT_MS * CYC_PER_MS;
	localparam int DOZE_CYCLE_CYC = DOZE_CYCLE_MS * CYC_PER_MS;
	localparam int DOZE_ACTIVE_CYC = DOZE_ACTIVE_MS * CYC_PER_MS;
	localparam int DOZE_DWELL_CYC = DOZE_DWELL_MS * CYC_PER_MS;
	localparam logic [7:0] BCAST_ADDR = 8'hFF;
	localparam logic [7:0] DEFAULT_GROUP = 8'hA0;
	localparam logic [2:0] DOZE_EN_BIT = 3'h7;
	localparam logic [2:0] CTRL_FREQ_BIT = 3'h6;
	localparam logic [2:0] ADDR_CHK_BIT = 3'h0;
	localparam logic [3:0] CTRL_REPEATS = 4'h2;
	localparam logic [3:0] SCAN_REPEATS = 4'h4;
	localparam logic [7:0] ASCII_AT = 8'h40;
	localparam logic [7:0] ASCII_R = 8'h52;
	localparam logic [7:0] ASCII_L = 8'h4C;
	localparam logic [7:0] ASCII_CR = 8'h0D;
	localparam logic [7:0] ASCII_LF = 8'h0A;
	localparam int CNT_W = 32;
	typedef enum logic [1:0] {
		RESP_ACCEPTED = 2'h0,
		RESP_SUCCESS  = 2'h1,
		RESP_FAILURE  = 2'h2
	} resp_t;
	typedef enum logic [2:0] {
		P_AT   = 3'h0,
		P_C1   = 3'h1,
		P_C2   = 3'h2,
		P_C3   = 3'h3,
		P_RPT  = 3'h4,
		P_DST  = 3'h5,
		P_CR   = 3'h6,
		P_LF   = 3'h7
	} parse_t;
	typedef enum logic [2:0] {
		S_IDLE   = 3'h0,
		S_ACCEPT = 3'h1,
		S_SEND   = 3'h2,
		S_WAIT   = 3'h3,
		S_FINAL  = 3'h4
	} seq_t;
endpackage

//--- tb/radio_peer.sv
// remote sender model feeding wake transmission requests to the repeater
`timescale 1ns/1ns
module radio_peer (
	input  wire logic       ref_clk,
	input  wire logic       fire,
	input  wire logic [7:0] rpt,
	input  wire logic [7:0] dst,
	input  wire logic       ack,
	output logic            rx_req_valid,
	output logic      [7:0] rx_req_repeater,
	output logic      [7:0] rx_req_dest,
	output logic            rx_ack_valid
);
	logic [7:0] last_rpt = 8'h00;
	logic [7:0] last_dst = 8'h00;
	// fields show garbage between packets so stale values cannot match
	always @(negedge ref_clk) if (fire) begin
		last_rpt <= rpt;
		last_dst <= dst;
	end
	assign rx_req_valid = fire;
	assign rx_req_repeater = fire ? rpt : ~last_rpt;
	assign rx_req_dest = fire ? dst : ~last_dst;
	assign rx_ack_valid = ack;
endmodule

//--- tb/testbench.sv
// self-checking bench for the wake sequencer
`timescale 1ns/1ns
module testbench;
	import wake_seq_pkg::*;
`define CHK(n,e,g) begin num_checks++; if ((g) !== (e)) begin \
	$display("wrong value %s exp %h got %h", n, e, g); n_errors++; end end
	logic ref_clk = 1'b0, rst_b = 1'b0, host_valid = 1'b0, dozing = 1'b0;
	logic single_freq_mode = 1'b1, fire = 1'b0, ack = 1'b0;
	logic [7:0] host_byte = 8'h00, station_address_setting = 8'h05;
	logic [7:0] channel_group_setting = 8'hA0, retry_count_setting = 8'h01;
	logic [7:0] relay_address_check_setting = 8'h00;
	logic [7:0] doze_config_setting = 8'h80, rpt = 8'h00, dst = 8'h00;
	logic [3:0] group_freq_count = 4'h3;
	logic [7:0] group_low_freq = 8'h00, group_freq_step = 8'h08;
	logic rx_req_valid, rx_ack_valid, resp_valid, tx_req_valid;
	logic tx_wake_valid, tx_ack_valid, ctrl_freq_active, rx_awake;
	logic [7:0] rx_req_repeater, rx_req_dest, tx_req_repeater, tx_req_dest;
	logic [7:0] tx_wake_dest, tx_freq, data_low_freq, listen_freq;
	resp_t resp_code;
	int n_errors = 0, num_checks = 0;
	radio_wakeup_sequencer uut (
		.ref_clk                    (ref_clk),
		.rst_b                      (rst_b),
		.host_valid                 (host_valid),
		.host_byte                  (host_byte),
		.resp_valid                 (resp_valid),
		.resp_code                  (resp_code),
		.station_address_setting    (station_address_setting),
		.channel_group_setting      (channel_group_setting),
		.retry_count_setting        (retry_count_setting),
		.relay_address_check_setting(relay_address_check_setting),
		.doze_config_setting        (doze_config_setting),
		.single_freq_mode           (single_freq_mode),
		.group_freq_count           (group_freq_count),
		.group_low_freq             (group_low_freq),
		.group_freq_step            (group_freq_step),
		.dozing                     (dozing),
		.rx_req_valid               (rx_req_valid),
		.rx_req_repeater            (rx_req_repeater),
		.rx_req_dest                (rx_req_dest),
		.rx_ack_valid               (rx_ack_valid),
		.tx_req_valid               (tx_req_valid),
		.tx_req_repeater            (tx_req_repeater),
		.tx_req_dest                (tx_req_dest),
		.tx_wake_valid              (tx_wake_valid),
		.tx_wake_dest               (tx_wake_dest),
		.tx_freq                    (tx_freq),
		.tx_ack_valid               (tx_ack_valid),
		.ctrl_freq_active           (ctrl_freq_active),
		.data_low_freq              (data_low_freq),
		.rx_awake                   (rx_awake),
		.listen_freq                (listen_freq)
	);
	radio_peer peer (
		.ref_clk        (ref_clk),
		.fire           (fire),
		.rpt            (rpt),
		.dst            (dst),
		.ack            (ack),
		.rx_req_valid   (rx_req_valid),
		.rx_req_repeater(rx_req_repeater),
		.rx_req_dest    (rx_req_dest),
		.rx_ack_valid   (rx_ack_valid)
	);
	initial forever #5 ref_clk = ~ref_clk;
	task stop_test;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task do_reset;
		rst_b = 1'b0;
		repeat (10) @(negedge ref_clk);
		rst_b = 1'b1;
	endtask
	task send(input string s);
		for (int i = 0; i < s.len(); i++) begin
			host_valid = 1'b1;
			host_byte = s[i];
			@(negedge ref_clk);
		end
		host_valid = 1'b0;
	endtask
	// command prefix built from its byte codes, then the address fields
	task send_cmd(input string a);
		send($sformatf("%c%c%c%c%s", ASCII_AT, ASCII_R, ASCII_L, ASCII_R, a));
	endtask
	task t_cmd(input string s, input logic [7:0] r, input logic [7:0] d);
		send_cmd(s);
		`CHK("early resp", 1'b0, resp_valid)
		@(negedge ref_clk);
		`CHK("resp_valid", 1'b1, resp_valid)
		`CHK("resp_code", RESP_ACCEPTED, resp_code)
		@(negedge ref_clk);
		`CHK("resp pulse", 1'b0, resp_valid)
		`CHK("tx_req_valid", 1'b1, tx_req_valid)
		`CHK("tx_req_repeater", r, tx_req_repeater)
		`CHK("tx_req_dest", d, tx_req_dest)
		@(negedge ref_clk);
		`CHK("req pulse", 1'b0, tx_req_valid)
		// host traffic after a wake must not start a second sequence
		send_cmd("1 2\015\n");
		repeat (6) begin
			@(negedge ref_clk);
			`CHK("busy resp", 1'b0, resp_valid)
		end
		do_reset();
		$display("command test done");
	endtask
	task pulse(input logic [7:0] r, input logic [7:0] d);
		rpt = r;
		dst = d;
		fire = 1'b1;
		@(negedge ref_clk);
		fire = 1'b0;
		@(negedge ref_clk);
	endtask
	task t_relay;
		single_freq_mode = 1'b1;
		relay_address_check_setting = 8'h01;
		pulse(8'h09, 8'h21);
		`CHK("wake on mismatch", 1'b0, tx_wake_valid)
		pulse(8'h05, 8'h21);
		`CHK("tx_wake_valid", 1'b1, tx_wake_valid)
		`CHK("tx_wake_dest", 8'h21, tx_wake_dest)
		ack = 1'b1;
		@(negedge ref_clk);
		ack = 1'b0;
		`CHK("tx_ack_valid", 1'b0, tx_ack_valid)
		do_reset();
		relay_address_check_setting = 8'h00;
		pulse(8'h09, 8'h33);
		`CHK("wake unchecked", 8'h33, tx_wake_dest)
		`CHK("wake unchecked valid", 1'b1, tx_wake_valid)
		do_reset();
		$display("relay test done");
	endtask
	task t_ctrl;
		logic c;
		for (int m = 0; m < 4; m++) begin
			single_freq_mode = m[1];
			doze_config_setting = {1'b1, m[0], 6'h00};
			c = m[0] && !m[1];
			#1;
			`CHK("ctrl_freq_active", c, ctrl_freq_active)
			`CHK("data_low_freq", c ? 8'h08 : 8'h00, data_low_freq)
			@(negedge ref_clk);
		end
		single_freq_mode = 1'b0;
		doze_config_setting = 8'hC0;
		group_low_freq = 8'h10;
		@(negedge ref_clk);
		dozing = 1'b1;
		repeat (20) @(negedge ref_clk);
		`CHK("listen_freq", 8'h10, listen_freq)
		`CHK("rx_awake", 1'b1, rx_awake)
		`CHK("tx_freq", 8'h10, tx_freq)
		`CHK("data_low_freq ctrl", 8'h18, data_low_freq)
		doze_config_setting = 8'h40;
		repeat (2) @(negedge ref_clk);
		`CHK("rx_awake off", 1'b0, rx_awake)
		`CHK("ctrl off", 1'b0, ctrl_freq_active)
		dozing = 1'b0;
		$display("control frequency test done");
	endtask
	initial begin
		#100000;
		n_errors++;
		stop_test();
	end
	initial begin
		do_reset();
		t_cmd("12 255\015\n", 8'h0C, 8'hFF);
		t_cmd("3 7\015\n", 8'h03, 8'h07);
		t_relay();
		t_ctrl();
		stop_test();
	end
endmodule

//--- tb/wake_seq_checker.sv
// concurrent checks on the wake sequencer ports
`timescale 1ns/1ns
module wake_seq_checker
	import wake_seq_pkg::*;
(
	input wire logic       ref_clk,
	input wire logic       rst_b,
	input wire logic       resp_valid,
	input resp_t           resp_code,
	input wire logic       tx_req_valid,
	input wire logic [7:0] tx_req_dest,
	input wire logic       rx_req_valid,
	input wire logic [7:0] rx_req_repeater,
	input wire logic [7:0] station_address_setting,
	input wire logic [7:0] relay_address_check_setting,
	input wire logic [7:0] doze_config_setting,
	input wire logic       single_freq_mode,
	input wire logic [7:0] group_low_freq,
	input wire logic [7:0] group_freq_step,
	input wire logic       tx_wake_valid,
	input wire logic       tx_ack_valid,
	input wire logic       ctrl_freq_active,
	input wire logic [7:0] data_low_freq
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	wire logic acc = resp_valid && resp_code == RESP_ACCEPTED;
	wire logic chk_on = relay_address_check_setting[0];
	wire logic hit = rx_req_repeater == station_address_setting;
	property p_no_ack; !tx_ack_valid; endproperty
	a_no_ack: assert property (p_no_ack) else $error("ack sent");
	property p_drop;
		rx_req_valid && chk_on && !hit && !tx_wake_valid |=> !tx_wake_valid;
	endproperty
	a_drop: assert property (p_drop) else $error("foreign req taken");
	property p_relay;
		rx_req_valid && (!chk_on || hit) |-> ##[1:2] tx_wake_valid;
	endproperty
	a_relay: assert property (p_relay) else $error("no relay burst");
	property p_req_after; acc |=> tx_req_valid; endproperty
	a_req_after: assert property (p_req_after) else $error("no request");
	property p_one_resp; acc |=> !resp_valid [*8]; endproperty
	a_one_resp: assert property (p_one_resp) else $error("extra resp");
	property p_ctrl_sel;
		doze_config_setting[7] && !single_freq_mode
			|-> ctrl_freq_active == doze_config_setting[6];
	endproperty
	a_ctrl_sel: assert property (p_ctrl_sel) else $error("ctrl sel");
	property p_single; single_freq_mode |-> !ctrl_freq_active; endproperty
	a_single: assert property (p_single) else $error("ctrl in single");
	property p_data_low;
		data_low_freq == (ctrl_freq_active ?
			8'(group_low_freq + group_freq_step) : group_low_freq);
	endproperty
	a_data_low: assert property (p_data_low) else $error("data low");
	property p_spacing; tx_req_valid |=> !tx_req_valid; endproperty
	a_spacing: assert property (p_spacing) else $error("req spacing");
	property p_final;
		resp_valid && resp_code != RESP_ACCEPTED |-> resp_code ==
			((tx_req_dest == BCAST_ADDR) ? RESP_SUCCESS : RESP_FAILURE);
	endproperty
	a_final: assert property (p_final) else $error("final resp");
	c_acc: cover property (acc);
	c_wake: cover property ($rose(tx_wake_valid));
	c_ctrl: cover property (ctrl_freq_active);
endmodule
bind radio_wakeup_sequencer wake_seq_checker chk (.*);
